// file: src/wake_sequencer.sv
// Operation
// - five wake sources: power key, reset key, alarm, modem ring, docking
// - power key while off powers on and runs the selected on-process
// - reset key while off powers on and selects maintenance-menu boot; while on it powers off
// - normal off in application: resume if enabled, else application boot
// - critical battery off resumes; reset-key off leads to menu boot
// - non-reset off during maintenance menu leads to application boot
// - resume by default; boot override applies once then clears
// - alarm wakes for resume only, suppressed when next start is boot
// - ring wake disabled after reset until software enables it
// - docking wake enabled after reset, software may disable it
// - docking wake only while the cradle has power
module wake_sequencer #(
    parameter int unsigned SETTLE = wake_pkg::SETTLE_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       power_key_i,
    input  wire logic       reset_key_i,
    input  wire logic       alarm_i,
    input  wire logic       ring_i,
    input  wire logic       docked_i,
    input  wire logic       cradle_powered_i,
    input  wire logic       resume_en_i,
    input  wire logic       boot_override_set_i,
    input  wire logic       ring_en_set_i,
    input  wire logic       ring_en_clr_i,
    input  wire logic       dock_en_set_i,
    input  wire logic       dock_en_clr_i,
    input  wire logic       off_req_i,
    input  wire logic [2:0] off_cause_i,
    input  wire logic       menu_running_i,
    output logic            power_on_o,
    output logic            start_o,
    output logic [1:0]      on_proc_o,
    output logic [2:0]      last_off_cause_o,
    output logic            menu_ctx_o,
    output logic            ring_en_o,
    output logic            dock_en_o,
    output logic            boot_override_o
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // wake source edges

    logic [wake_pkg::NUM_SRC-1:0] src_level;
    logic [wake_pkg::NUM_SRC-1:0] src_rise;

    assign src_level[wake_pkg::SRC_POWER] = power_key_i;
    assign src_level[wake_pkg::SRC_RESET] = reset_key_i;
    assign src_level[wake_pkg::SRC_ALARM] = alarm_i;
    assign src_level[wake_pkg::SRC_RING]  = ring_i;
    assign src_level[wake_pkg::SRC_DOCK]  = docked_i & cradle_powered_i;

    wake_edge_detect #(
        .WIDTH (wake_pkg::NUM_SRC)
    ) u_edge (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .level_i (src_level),
        .rise_o  (src_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // settings and retained context

    wake_pkg::seq_state_e   state_q, state_d;
    wake_pkg::off_cause_e   cause_q, cause_d;
    wake_pkg::on_proc_e     proc_q, proc_d;
    logic                   menu_q, menu_d;
    logic                   ring_en_q, ring_en_d;
    logic                   dock_en_q, dock_en_d;
    logic                   ovr_q, ovr_d;
    logic                   start_q, start_d;
    logic [31:0]            cnt_q, cnt_d;
    wake_pkg::on_proc_e     sel;
    logic                   next_is_boot;
    logic                   wake_normal;
    logic                   wake_alarm;

    // choose the on-process from the retained context
    always_comb begin
        sel = wake_pkg::ON_APP_BOOT;
        if (cause_q == wake_pkg::OFF_RESET_KEY) begin
            sel = wake_pkg::ON_MENU_BOOT;
        end else if (menu_q) begin
            sel = wake_pkg::ON_APP_BOOT;
        end else if (cause_q == wake_pkg::OFF_LOW_BATT_CRT) begin
            sel = wake_pkg::ON_RESUME;
        end else if (cause_q == wake_pkg::OFF_NONE) begin
            // nothing was saved yet: cold start boots the application
            sel = wake_pkg::ON_APP_BOOT;
        end else begin
            sel = (resume_en_i && !ovr_q) ? wake_pkg::ON_RESUME : wake_pkg::ON_APP_BOOT;
        end
    end

    assign next_is_boot = (sel != wake_pkg::ON_RESUME);
    assign wake_normal  = src_rise[wake_pkg::SRC_POWER]
                        | (src_rise[wake_pkg::SRC_RING] & ring_en_q)
                        | (src_rise[wake_pkg::SRC_DOCK] & dock_en_q);
    assign wake_alarm   = src_rise[wake_pkg::SRC_ALARM] & ~next_is_boot;

    always_comb begin
        state_d   = state_q;
        cause_d   = cause_q;
        proc_d    = proc_q;
        menu_d    = menu_q;
        ovr_d     = ovr_q;
        start_d   = 1'b0;
        cnt_d     = cnt_q;
        // set wins over clear for the wake enables
        ring_en_d = ring_en_set_i ? 1'b1 : (ring_en_clr_i ? 1'b0 : ring_en_q);
        dock_en_d = dock_en_set_i ? 1'b1 : (dock_en_clr_i ? 1'b0 : dock_en_q);
        case (state_q)
            wake_pkg::ST_OFF: begin
                cnt_d = '0;
                if (src_rise[wake_pkg::SRC_RESET]) begin
                    proc_d  = wake_pkg::ON_MENU_BOOT;
                    state_d = wake_pkg::ST_POWERUP;
                end else if (wake_normal || wake_alarm) begin
                    proc_d  = sel;
                    state_d = wake_pkg::ST_POWERUP;
                end
                // one-shot override is used up by this wake
                if (state_d != wake_pkg::ST_OFF) begin
                    ovr_d = 1'b0;
                end
            end
            wake_pkg::ST_POWERUP: begin
                if (cnt_q >= SETTLE - 1) begin
                    start_d = 1'b1;
                    state_d = wake_pkg::ST_ON;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            wake_pkg::ST_ON: begin
                // reset key while on records a reset-key off
                if (src_rise[wake_pkg::SRC_RESET]) begin
                    cause_d = wake_pkg::OFF_RESET_KEY;
                    menu_d  = 1'b0;
                    state_d = wake_pkg::ST_OFF;
                end else if (off_req_i) begin
                    cause_d = wake_pkg::off_cause_e'(off_cause_i);
                    menu_d  = menu_running_i;
                    state_d = wake_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = wake_pkg::ST_OFF;
            end
        endcase
        // a set in the same cycle as the clear wins
        if (boot_override_set_i) begin
            ovr_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= wake_pkg::ST_OFF;
            cause_q   <= wake_pkg::OFF_NONE;
            proc_q    <= wake_pkg::ON_NONE;
            menu_q    <= 1'b0;
            ring_en_q <= wake_pkg::RING_EN_RESET;
            dock_en_q <= wake_pkg::DOCK_EN_RESET;
            ovr_q     <= 1'b0;
            start_q   <= 1'b0;
            cnt_q     <= '0;
        end else begin
            state_q   <= state_d;
            cause_q   <= cause_d;
            proc_q    <= proc_d;
            menu_q    <= menu_d;
            ring_en_q <= ring_en_d;
            dock_en_q <= dock_en_d;
            ovr_q     <= ovr_d;
            start_q   <= start_d;
            cnt_q     <= cnt_d;
        end
    end

    assign power_on_o       = (state_q != wake_pkg::ST_OFF);
    assign start_o          = start_q;
    assign on_proc_o        = proc_q;
    assign last_off_cause_o = cause_q;
    assign menu_ctx_o       = menu_q;
    assign ring_en_o        = ring_en_q;
    assign dock_en_o        = dock_en_q;
    assign boot_override_o  = ovr_q;

endmodule : wake_sequencer

// file: pkg/wake_pkg.sv
package wake_pkg;

    // off causes, held across the off state
    typedef enum logic [2:0] {
        OFF_NONE         = 3'h0,
        OFF_POWER_KEY    = 3'h1,
        OFF_IDLE_TIMEOUT = 3'h2,
        OFF_SOFTWARE     = 3'h3,
        OFF_LOW_BATT_WRN = 3'h4,
        OFF_LOW_BATT_CRT = 3'h5,
        OFF_RESET_KEY    = 3'h6
    } off_cause_e;

    // on-process selected at wake
    typedef enum logic [1:0] {
        ON_NONE      = 2'h0,
        ON_RESUME    = 2'h1,
        ON_APP_BOOT  = 2'h2,
        ON_MENU_BOOT = 2'h3
    } on_proc_e;

    // sequencer states
    typedef enum logic [1:0] {
        ST_OFF     = 2'h0,
        ST_POWERUP = 2'h1,
        ST_ON      = 2'h2
    } seq_state_e;

    // wake source index
    localparam int unsigned SRC_POWER = 0;
    localparam int unsigned SRC_RESET = 1;
    localparam int unsigned SRC_ALARM = 2;
    localparam int unsigned SRC_RING  = 3;
    localparam int unsigned SRC_DOCK  = 4;
    localparam int unsigned NUM_SRC   = 5;

    // power rail settling time before the on-process starts
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned SETTLE_US      = 10;
    localparam int unsigned SETTLE_CYCLES  = (SETTLE_US * (CLK_HZ / 1_000_000));

    localparam logic RING_EN_RESET  = 1'b0;
    localparam logic DOCK_EN_RESET  = 1'b1;

endpackage : wake_pkg

// file: src/wake_edge_detect.sv
module wake_edge_detect #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o
);

    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    always_comb begin
        prev_d = level_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // one pulse per press, so a held key wakes only once
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_edge
            assign rise_o[g] = level_i[g] & ~prev_q[g];
        end
    endgenerate

endmodule : wake_edge_detect

// file: sim/wake_sequencer_properties.sv
module wake_sequencer_checker #(
    parameter int unsigned SETTLE = 4
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       reset_key_i,
    input wire logic       boot_override_set_i,
    input wire logic       off_req_i,
    input wire logic [2:0] off_cause_i,
    input wire logic       menu_running_i,
    input wire logic       power_on_o,
    input wire logic       start_o,
    input wire logic [1:0] on_proc_o,
    input wire logic [2:0] last_off_cause_o,
    input wire logic       menu_ctx_o,
    input wire logic       ring_en_o,
    input wire logic       dock_en_o,
    input wire logic       boot_override_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAIT_MAX = SETTLE + 6;
    logic on_d;
    logic on_q;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // off requests only count once the on-process has started
    assign on_d = start_o | (on_q & power_on_o);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) on_q <= 1'b0;
        else on_q <= on_d;
    end
    ////////////////////////////////////////////////////////////////
    AST_START_PULSE: assert property (start_o |=> !start_o)
        else $error("start held more than one cycle");
    AST_START_ON: assert property (start_o |-> power_on_o)
        else $error("start without power");
    AST_RESET_MENU: assert property ($rose(reset_key_i) && !power_on_o |->
        ##[1:WAIT_MAX] (start_o && on_proc_o == 2'h3))
        else $error("reset key did not start menu boot");
    AST_OVR_SET: assert property (boot_override_set_i |=> boot_override_o)
        else $error("override not set");
    AST_OVR_CLEAR: assert property ($rose(power_on_o) && !$past(boot_override_set_i) |->
        !boot_override_o)
        else $error("override not cleared at power-on");
    AST_OFF_LATCH: assert property (on_q && power_on_o && off_req_i && !reset_key_i |=>
        !power_on_o && last_off_cause_o == $past(off_cause_i)
        && menu_ctx_o == $past(menu_running_i))
        else $error("off cause not latched");
    AST_RETAIN: assert property (!power_on_o |=>
        $stable(last_off_cause_o) && $stable(menu_ctx_o))
        else $error("off record changed while off");
    AST_RESET_VALUES: assert property ($rose(rst_n_i) |->
        !ring_en_o && dock_en_o && !boot_override_o)
        else $error("enables wrong after reset");
endmodule : wake_sequencer_checker

bind wake_sequencer wake_sequencer_checker #(.SETTLE(SETTLE)) wake_sequencer_checker_i (
    .clk_i               (clk_i),
    .rst_n_i             (rst_n_i),
    .reset_key_i         (reset_key_i),
    .boot_override_set_i (boot_override_set_i),
    .off_req_i           (off_req_i),
    .off_cause_i         (off_cause_i),
    .menu_running_i      (menu_running_i),
    .power_on_o          (power_on_o),
    .start_o             (start_o),
    .on_proc_o           (on_proc_o),
    .last_off_cause_o    (last_off_cause_o),
    .menu_ctx_o          (menu_ctx_o),
    .ring_en_o           (ring_en_o),
    .dock_en_o           (dock_en_o),
    .boot_override_o     (boot_override_o)
);

// file: sim/wake_far_side.sv
module wake_far_side (
    input  wire logic       clk_i,
    output logic      [4:0] src_o,
    output logic            cradle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // released keys and lines sit low, as if pulled down
    initial begin
        src_o = 5'h00;
        cradle_o = 1'b0;
    end
    task automatic drive(input int unsigned idx, input logic val);
        @(posedge clk_i);
        src_o[idx] <= val;
    endtask : drive
    task automatic supply(input logic val);
        @(posedge clk_i);
        cradle_o <= val;
    endtask : supply
endmodule : wake_far_side

// file: sim/test_wake_sequencer.sv
module test_wake_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       resume_en_i = 1'b0;
    logic       off_req_i = 1'b0;
    logic       menu_running_i = 1'b0;
    logic [2:0] off_cause_i = 3'h0;
    logic [4:0] pls = 5'h00;
    logic [4:0] src;
    logic       cradle;
    logic       power_on_o, start_o, menu_ctx_o, ring_en_o, dock_en_o, boot_override_o;
    logic [1:0] on_proc_o;
    logic [2:0] last_off_cause_o;
    logic [2:0] c;
    logic       m, r, o, got;
    int         mismatches = 0;
    int         compares = 0;

    always #10 clk_i = ~clk_i;

    wake_far_side wake_far_side_i (
        .clk_i    (clk_i),
        .src_o    (src),
        .cradle_o (cradle)
    );
    wake_sequencer #(.SETTLE(4)) wake_sequencer_i (
        .power_key_i         (src[0]),
        .reset_key_i         (src[1]),
        .alarm_i             (src[2]),
        .ring_i              (src[3]),
        .docked_i            (src[4]),
        .cradle_powered_i    (cradle),
        .boot_override_set_i (pls[4]),
        .ring_en_set_i       (pls[3]),
        .ring_en_clr_i       (pls[2]),
        .dock_en_set_i       (pls[1]),
        .dock_en_clr_i       (pls[0]),
        .clk_i               (clk_i),
        .rst_n_i             (rst_n_i),
        .resume_en_i         (resume_en_i),
        .off_req_i           (off_req_i),
        .off_cause_i         (off_cause_i),
        .menu_running_i      (menu_running_i),
        .power_on_o          (power_on_o),
        .start_o             (start_o),
        .on_proc_o           (on_proc_o),
        .last_off_cause_o    (last_off_cause_o),
        .menu_ctx_o          (menu_ctx_o),
        .ring_en_o           (ring_en_o),
        .dock_en_o           (dock_en_o),
        .boot_override_o     (boot_override_o)
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [1:0] sel(input logic [2:0] cs, input logic mn,
                                       input logic re, input logic ov);
        if (cs == 3'h6) return 2'h3;
        if (mn || cs == 3'h0) return 2'h2;
        if (cs == 3'h5) return 2'h1;
        return (re && !ov) ? 2'h1 : 2'h2;
    endfunction : sel

    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic strobe(input logic [4:0] mk);
        @(posedge clk_i);
        pls <= mk;
        @(posedge clk_i);
        pls <= 5'h00;
        @(negedge clk_i);
    endtask : strobe

    task automatic off(input logic [2:0] cs, input logic mn, input logic re);
        @(posedge clk_i);
        off_req_i <= 1'b1;
        off_cause_i <= cs;
        menu_running_i <= mn;
        resume_en_i <= re;
        @(posedge clk_i);
        off_req_i <= 1'b0;
        @(negedge clk_i);
        chk("power_on", 3'h0, {2'h0, power_on_o});
        chk("off_cause", cs, last_off_cause_o);
        chk("menu_ctx", {2'h0, mn}, {2'h0, menu_ctx_o});
    endtask : off

    // waits longer than the settle count so a late start still shows
    task automatic wake(input int unsigned idx, input logic on, input logic [1:0] ep);
        wake_far_side_i.drive(idx, 1'b1);
        got = 1'b0;
        for (int k = 0; k < 12 && !got; k++) begin
            @(negedge clk_i);
            got = (start_o === 1'b1);
        end
        chk("woke", {2'h0, on}, {2'h0, got});
        chk("power_on", {2'h0, on}, {2'h0, power_on_o});
        if (on) begin
            chk("on_proc", {1'b0, ep}, {1'b0, on_proc_o});
            chk("override", 3'h0, {2'h0, boot_override_o});
        end
        wake_far_side_i.drive(idx, 1'b0);
    endtask : wake
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4F14));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("ring_en", 3'h0, {2'h0, ring_en_o});
        chk("dock_en", 3'h1, {2'h0, dock_en_o});
        chk("cause", 3'h0, last_off_cause_o);
        wake(0, 1'b1, 2'h2);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            c = 3'($urandom_range(1, 6));
            m = 1'($urandom_range(0, 1));
            r = 1'($urandom_range(0, 1));
            o = 1'($urandom_range(0, 1));
            if (o) strobe(5'h10);
            if (o) chk("override", 3'h1, {2'h0, boot_override_o});
            off(c, m, r);
            wake(0, 1'b1, sel(c, m, r, o));
        end
        $display("test random done");
        off(3'h1, 1'b0, 1'b1);
        wake(1, 1'b1, 2'h3);
        off(3'h1, 1'b0, 1'b1);
        wake(2, 1'b1, 2'h1);
        strobe(5'h10);
        off(3'h1, 1'b0, 1'b1);
        wake(2, 1'b0, 2'h0);
        wake(0, 1'b1, 2'h2);
        $display("test reset key and alarm done");
        off(3'h2, 1'b0, 1'b1);
        wake(3, 1'b0, 2'h0);
        strobe(5'h0C);
        chk("ring_en", 3'h1, {2'h0, ring_en_o});
        wake(3, 1'b1, 2'h1);
        off(3'h4, 1'b0, 1'b1);
        wake(4, 1'b0, 2'h0);
        wake_far_side_i.supply(1'b1);
        wake(4, 1'b1, 2'h1);
        strobe(5'h01);
        chk("dock_en", 3'h0, {2'h0, dock_en_o});
        off(3'h3, 1'b0, 1'b0);
        wake(4, 1'b0, 2'h0);
        wake(0, 1'b1, 2'h2);
        $display("test ring and dock done");
        tally_and_finish();
    end

    initial begin
        #400_000;
        mismatches++;
        tally_and_finish();
    end
endmodule : test_wake_sequencer
